// >>> wdc_pkg.sv
package wdc_pkg;

  // Wishbone side
  localparam int WDC_AW = 8;
  localparam int WDC_DW = 32;
  localparam int WDC_RW = 8;
  localparam logic [5:0] WDC_IDX_CTRL = 6'h00;
  localparam logic [5:0] WDC_IDX_STATUS = 6'h01;
  localparam int WDC_IDX_HI = 7;
  localparam int WDC_IDX_LO = 2;
  localparam int WDC_LANE0 = 0;

  // Status fields
  localparam int WDC_LOCK_BIT = 7;
  localparam int WDC_SYNC_BIT = 0;
  localparam logic [7:0] WDC_STATUS_RESET = 8'h00;

  // Period codes
  localparam logic [3:0] WDC_CODE_OFF = 4'h0;
  localparam logic [3:0] WDC_CODE_ONE = 4'h1;
  localparam logic [3:0] WDC_CODE_MAX = 4'hB;
  localparam logic [13:0] WDC_BASE_TICKS = 14'h0008;
  localparam logic [13:0] WDC_CNT_ONE = 14'h0001;

  // Oscillator ticks a restart needs to cross over
  localparam logic [1:0] WDC_RESTART_TICKS = 2'h2;
  localparam logic [1:0] WDC_RS_ONE = 2'h1;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } wdc_ctrl_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WDC_AW-1:0] adr;
    logic [3:0] sel;
    logic [WDC_DW-1:0] dat;
  } wdc_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [WDC_DW-1:0] dat;
  } wdc_wb_rsp_type;

  typedef enum {
    WDC_IDLE,
    WDC_NORMAL,
    WDC_CLOSED,
    WDC_OPEN
  } wdc_state_type;

endpackage : wdc_pkg

// >>> wdc_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module wdc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : wdc_sync2

`default_nettype wire

// >>> wdc_watchdog_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: Nonzero window code enables window mode
// R2: Nonzero timeout code runs the watchdog
// R3: Window mode uses timeout code as open window
// R4: Lock set makes control fields read-only
// R5: Lock only set; cleared only in debug
// R6: Nonzero timeout after boot sets lock
// R7: Control write raises sync pending flag
// R8: Hardware clears sync pending; reset zero
// R9: Lock write needs change protection unlock
// R10: Sync pending flag needs no unlock
// R11: Control reset value comes from fuse
// R12: Timeout without restart issues system reset
// R13: Closed-window restart resets; closed after first
// R14: Restart takes two ticks; extras ignored
// R15: Zero timeout keeps counter idle, no reset
module wdc_watchdog_ctrl
  import wdc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire wdc_pkg::wdc_wb_req_type wb_req,
  output var wdc_pkg::wdc_wb_rsp_type wb_rsp,
  input wire logic change_protection,
  input wire logic debug_mode,
  input wire logic boot_done,
  input wire wdc_pkg::wdc_ctrl_type boot_config_fuse,
  input wire logic watchdog_osc_clock,
  input wire logic watchdog_restart_instr,
  output logic system_reset_req
);

  import wdc_pkg::*;

  function automatic logic [13:0] code_ticks(input logic [3:0] code);
    logic [3:0] shift;
    // Reserved codes behave as the longest period
    shift = (code > WDC_CODE_MAX) ? WDC_CODE_MAX - WDC_CODE_ONE
                                  : code - WDC_CODE_ONE;
    code_ticks = WDC_BASE_TICKS << shift;
  endfunction : code_ticks

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  wdc_wb_rsp_type rsp_q;
  wdc_ctrl_type ctrl_q;
  wdc_ctrl_type wd_q;
  wdc_state_type state_q;
  logic lock_q;
  logic sync_pending_q;
  logic boot_seen_q;
  logic osc_s;
  logic osc_prev_q;
  logic osc_tick;
  logic rs_busy_q;
  logic [1:0] rs_cnt_q;
  logic restart_apply;
  logic [13:0] cnt_q;
  logic [13:0] cnt_inc;
  logic [13:0] limit;
  logic [5:0] idx;
  logic access;
  logic fire_wr;
  logic ctrl_wr;
  logic ctrl_wr_ok;
  logic status_wr;
  logic lock_set;
  logic lock_clr;
  logic boot_rise;
  logic [WDC_RW-1:0] rd_byte;

  assign idx = wb_req.adr[WDC_IDX_HI:WDC_IDX_LO];
  assign access = wb_req.cyc & wb_req.stb;
  // Effects land on the edge where the master sees ack
  assign fire_wr = access & wb_req.we & rsp_q.ack & wb_req.sel[WDC_LANE0];
  assign ctrl_wr = fire_wr & (idx == WDC_IDX_CTRL);
  assign status_wr = fire_wr & (idx == WDC_IDX_STATUS);
  // Writes during a crossing would corrupt the copy, so they drop
  assign ctrl_wr_ok = ctrl_wr & change_protection & ~lock_q // R4
                      & ~sync_pending_q;

  always_comb begin
    case (idx)
      WDC_IDX_CTRL: rd_byte = ctrl_q;
      WDC_IDX_STATUS: begin
        rd_byte = WDC_STATUS_RESET;
        rd_byte[WDC_LOCK_BIT] = lock_q;
        rd_byte[WDC_SYNC_BIT] = sync_pending_q; // R10
      end
      default: rd_byte = WDC_STATUS_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_q <= '0;
    end else begin
      rsp_q.ack <= access & ~rsp_q.ack;
      rsp_q.dat <= {{(WDC_DW-WDC_RW){1'b0}}, rd_byte};
    end
  end

  assign wb_rsp = rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control and lock

  assign boot_rise = boot_done & ~boot_seen_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      boot_seen_q <= 1'b0;
    end else if (boot_done) begin
      boot_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= boot_config_fuse; // R11
    end else if (ctrl_wr_ok) begin
      ctrl_q <= wdc_ctrl_type'(wb_req.dat[WDC_RW-1:0]);
    end
  end

  assign lock_set = (status_wr & change_protection // R9
                     & wb_req.dat[WDC_LOCK_BIT])
                    | (boot_rise & (ctrl_q.period != WDC_CODE_OFF)); // R6
  assign lock_clr = status_wr & change_protection & debug_mode
                    & ~wb_req.dat[WDC_LOCK_BIT]; // R5

  // Set beats clear when both arrive together
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_q <= WDC_STATUS_RESET[WDC_LOCK_BIT];
    end else if (lock_set) begin
      lock_q <= 1'b1; // R5
    end else if (lock_clr) begin
      lock_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator crossing

  wdc_sync2 #(.WIDTH(1)) u_osc_sync (
    .clk(clk),
    .reset(reset),
    .async_in(watchdog_osc_clock),
    .sync_out(osc_s)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
    end
  end

  assign osc_tick = osc_s & ~osc_prev_q;

  // Timer copy is taken on an oscillator tick, like a real crossing
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_pending_q <= WDC_STATUS_RESET[WDC_SYNC_BIT];
      wd_q <= boot_config_fuse; // R11
    end else if (ctrl_wr_ok) begin
      sync_pending_q <= 1'b1; // R7
    end else if (sync_pending_q & osc_tick) begin
      sync_pending_q <= 1'b0; // R8
      wd_q <= ctrl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart crossing

  assign restart_apply = rs_busy_q & osc_tick
                         & (rs_cnt_q == WDC_RESTART_TICKS - WDC_RS_ONE);

  always_ff @(posedge clk) begin
    if (reset) begin
      rs_busy_q <= 1'b0;
      rs_cnt_q <= '0;
    end else if (!rs_busy_q) begin
      rs_busy_q <= watchdog_restart_instr; // R14
      rs_cnt_q <= '0;
    end else if (restart_apply) begin
      rs_busy_q <= 1'b0;
    end else if (osc_tick) begin
      rs_cnt_q <= rs_cnt_q + WDC_RS_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout engine

  assign cnt_inc = cnt_q + WDC_CNT_ONE;

  always_comb begin
    case (state_q)
      WDC_CLOSED: limit = code_ticks(wd_q.window); // R1
      default: limit = code_ticks(wd_q.period); // R2 R3
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= WDC_IDLE;
      cnt_q <= '0;
    end else if (wd_q.period == WDC_CODE_OFF) begin
      state_q <= WDC_IDLE; // R15
      cnt_q <= '0;
    end else if (debug_mode) begin
      // Halt clears the count; the next run starts without a closed window
      state_q <= WDC_NORMAL;
      cnt_q <= '0;
    end else begin
      case (state_q)
        WDC_IDLE: begin
          state_q <= WDC_NORMAL;
          cnt_q <= '0;
        end
        WDC_NORMAL: begin
          if (restart_apply) begin
            cnt_q <= '0; // R12
            if (wd_q.window != WDC_CODE_OFF) begin
              state_q <= WDC_CLOSED; // R13
            end
          end else if (osc_tick) begin
            cnt_q <= cnt_inc;
          end
        end
        WDC_CLOSED: begin
          if (osc_tick & (cnt_inc == limit)) begin
            state_q <= WDC_OPEN;
            cnt_q <= '0;
          end else if (osc_tick) begin
            cnt_q <= cnt_inc;
          end
        end
        WDC_OPEN: begin
          if (restart_apply) begin
            state_q <= (wd_q.window != WDC_CODE_OFF) ? WDC_CLOSED
                                                     : WDC_NORMAL;
            cnt_q <= '0;
          end else if (osc_tick) begin
            cnt_q <= cnt_inc;
          end
        end
        default: begin
          state_q <= WDC_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Request holds until the block itself is reset
  always_ff @(posedge clk) begin
    if (reset) begin
      system_reset_req <= 1'b0;
    end else if ((state_q == WDC_NORMAL || state_q == WDC_OPEN)
                 && !debug_mode && wd_q.period != WDC_CODE_OFF
                 && osc_tick && !restart_apply && cnt_inc == limit) begin
      system_reset_req <= 1'b1; // R12
    end else if (state_q == WDC_CLOSED && restart_apply && !debug_mode
                 && wd_q.period != WDC_CODE_OFF) begin
      system_reset_req <= 1'b1; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_lock_blocks_ctrl: assert property ( // R4
    ctrl_wr && lock_q |=> $stable(ctrl_q))
    else $error("control changed while locked");

  a_lock_stays_set: assert property ( // R5
    lock_q && !debug_mode |=> lock_q)
    else $error("lock cleared outside debug");

  a_boot_auto_lock: assert property ( // R6
    boot_rise && ctrl_q.period != WDC_CODE_OFF |=> lock_q)
    else $error("lock not set after boot");

  a_sync_raise: assert property ( // R7
    ctrl_wr_ok |=> sync_pending_q && ctrl_q == $past(wb_req.dat[WDC_RW-1:0]))
    else $error("sync pending not raised on write");

  a_sync_finish: assert property ( // R8
    sync_pending_q && osc_tick |=> !sync_pending_q && wd_q == ctrl_q)
    else $error("sync pending not cleared after copy");

  a_lock_needs_unlock: assert property ( // R9
    status_wr && !change_protection && !boot_rise |=> $stable(lock_q))
    else $error("lock changed without unlock");

  a_idle_no_reset: assert property ( // R15
    wd_q.period == WDC_CODE_OFF && !system_reset_req
    |=> state_q == WDC_IDLE && !system_reset_req)
    else $error("idle watchdog issued reset");

  a_closed_restart: assert property ( // R13
    state_q == WDC_CLOSED && restart_apply && !debug_mode
    && wd_q.period != WDC_CODE_OFF |=> system_reset_req)
    else $error("early restart did not reset");

  a_restart_ignored: assert property ( // R14
    rs_busy_q && !osc_tick && watchdog_restart_instr |=> rs_busy_q
    && $stable(rs_cnt_q))
    else $error("restart accepted while synchronizing");

  a_window_entry: assert property ( // R1
    state_q == WDC_NORMAL && restart_apply && !debug_mode
    && wd_q.period != WDC_CODE_OFF && wd_q.window != WDC_CODE_OFF
    |=> state_q == WDC_CLOSED && cnt_q == '0)
    else $error("window mode not entered on restart");

  a_normal_timeout: assert property ( // R12
    state_q == WDC_NORMAL && osc_tick && !restart_apply && !debug_mode
    && wd_q.period != WDC_CODE_OFF
    && cnt_q == code_ticks(wd_q.period) - WDC_CNT_ONE |=> system_reset_req)
    else $error("normal timeout did not reset");

  a_restart_fresh: assert property ( // R12
    state_q == WDC_NORMAL && restart_apply && !debug_mode
    && wd_q.period != WDC_CODE_OFF |=> cnt_q == '0)
    else $error("restart did not start a fresh period");

  c_ctrl_write: cover property (ctrl_wr_ok ##[1:200] !sync_pending_q);
  c_open_restart: cover property (state_q == WDC_OPEN && restart_apply);
  c_timeout: cover property ($rose(system_reset_req));
  c_lock_clear: cover property (lock_q && lock_clr && !lock_set);

endmodule : wdc_watchdog_ctrl

`default_nettype wire

// >>> wdc_watchdog_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wdc_watchdog_ctrl_tb;
  import wdc_pkg::*;
  logic clk, reset, cp, dbg, boot, rs_i, osc_run, sys_rst;
  wdc_wb_req_type wb_req;
  wdc_wb_rsp_type wb_rsp;
  wdc_ctrl_type fuse;
  logic [2:0] osc_q;
  logic [7:0] rd;
  int bad_count, check_count;

  wdc_watchdog_ctrl dut_u (
    .clk(clk),
    .reset(reset),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .change_protection(cp),
    .debug_mode(dbg),
    .boot_done(boot),
    .boot_config_fuse(fuse),
    .watchdog_osc_clock(osc_q[2]),
    .watchdog_restart_instr(rs_i),
    .system_reset_req(sys_rst)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Oscillator of 8 clocks; parked low while stopped
  always @(posedge clk) begin
    osc_q <= osc_run ? osc_q + 3'h1 : 3'h0;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h000000, d}};
    // Only the watchdog process ends a missing answer
    do begin
      @(posedge clk);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask : bus

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp);
  endtask : rc

  task automatic do_reset(input logic [7:0] f);
    osc_run <= 1'b0;
    fuse <= f;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  task automatic ticks(input int n);
    repeat (n * 8) @(posedge clk);
  endtask : ticks

  task automatic restart;
    @(posedge clk);
    rs_i <= 1'b1;
    @(posedge clk);
    rs_i <= 1'b0;
  endtask : restart

  ////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    do_reset(8'h03);
    rc(8'h00, 8'h03);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h00);
    bus(1'b1, 8'h00, 8'h25);
    rc(8'h00, 8'h03);
    cp <= 1'b1;
    bus(1'b1, 8'h00, 8'h25);
    rc(8'h04, 8'h01);
    osc_run <= 1'b1;
    ticks(3);
    rc(8'h04, 8'h00);
    rc(8'h00, 8'h25);
    cp <= 1'b0;
    bus(1'b1, 8'h04, 8'h80);
    rc(8'h04, 8'h00);
    cp <= 1'b1;
    bus(1'b1, 8'h04, 8'h81);
    rc(8'h04, 8'h80);
    bus(1'b1, 8'h00, 8'h00);
    rc(8'h00, 8'h25);
    bus(1'b1, 8'h04, 8'h00);
    rc(8'h04, 8'h80);
    dbg <= 1'b1;
    bus(1'b1, 8'h04, 8'h00);
    rc(8'h04, 8'h00);
    dbg <= 1'b0;
    cp <= 1'b0;
  endtask : t_regs

  task automatic t_boot_timeout;
    do_reset(8'h01);
    boot <= 1'b1;
    rc(8'h04, 8'h80);
    osc_run <= 1'b1;
    ticks(5);
    check({7'h00, sys_rst}, 8'h00);
    ticks(7);
    check({7'h00, sys_rst}, 8'h01);
    boot <= 1'b0;
  endtask : t_boot_timeout

  task automatic t_restart;
    do_reset(8'h01);
    osc_run <= 1'b1;
    repeat (6) begin
      ticks(4);
      restart();
    end
    check({7'h00, sys_rst}, 8'h00);
  endtask : t_restart

  task automatic t_off;
    do_reset(8'h10);
    osc_run <= 1'b1;
    restart();
    ticks(40);
    check({7'h00, sys_rst}, 8'h00);
  endtask : t_off

  // Closed 8 ticks, open 16 ticks; the early double pulse must be dropped
  task automatic t_window;
    do_reset(8'h12);
    osc_run <= 1'b1;
    restart();
    ticks(1);
    restart();
    ticks(17);
    check({7'h00, sys_rst}, 8'h00);
    // Restart lands ten ticks into the open window, past a closed length
    restart();
    ticks(5);
    check({7'h00, sys_rst}, 8'h00);
    restart();
    ticks(5);
    check({7'h00, sys_rst}, 8'h01);
  endtask : t_window

  ////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    check_count = 0;
    cp <= 1'b0;
    dbg <= 1'b0;
    boot <= 1'b0;
    rs_i <= 1'b0;
    wb_req <= '0;
    t_regs();
    t_boot_timeout();
    t_restart();
    t_off();
    t_window();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : wdc_watchdog_ctrl_tb
`default_nettype wire
